/* bus_model.sv */
// Memory and peripheral bus model that answers the block's requests.
`timescale 1ns/1ns
`default_nettype none
module bus_model #(parameter int RETRY = 3) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_periph,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic mem_ack,
    output logic mem_retry,
    output logic [31:0] mem_rdata
);
    logic [31:0] m [16];
    int n;
    // Answers every other cycle; a peripheral write is refused RETRY times before it lands.
    always @(posedge mclk) begin
        mem_ack <= mem_req && !mem_ack && !srst;
        mem_retry <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (srst) begin
            n <= 0;
            mem_rdata <= '0;
            for (int i = 0; i < 16; i++) m[i] <= 32'h5a5a_0000 + 32'(i * 4);
        end else if (mem_req && !mem_ack) begin
            mem_rdata <= m[mem_addr[5:2]];
            if (mem_we && mem_periph && n < RETRY) begin
                mem_retry <= 1'b1;
                n <= n + 1;
            end else if (mem_we) begin
                n <= 0;
                for (int b = 0; b < 4; b++) begin
                    if (mem_be[b]) m[mem_addr[5:2]][b*8+:8] <= mem_wdata[b*8+:8];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* sbuf_match.sv */
// Youngest-first byte merge of buffered store data for one load address.
`timescale 1ns/1ns
`default_nettype none
module sbuf_match #(
    parameter int DEPTH = sbuf_pkg::SB_DEPTH
) (
    input wire logic [sbuf_pkg::ADDR_W-1:0] ld_addr,
    input wire logic [DEPTH-1:0] ent_vld,
    input wire logic [DEPTH-1:0][sbuf_pkg::ADDR_W-1:0] ent_addr,
    input wire logic [DEPTH-1:0][sbuf_pkg::DATA_W-1:0] ent_data,
    input wire logic [DEPTH-1:0][sbuf_pkg::BE_W-1:0] ent_be,
    output logic [sbuf_pkg::DATA_W-1:0] fwd_data,
    output logic [sbuf_pkg::BE_W-1:0] fwd_be
);
    import sbuf_pkg::*;

    // Oldest entry is index 0; later entries overwrite earlier bytes.
    always_comb begin
        fwd_data = '0;
        fwd_be = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (ent_vld[i] && ent_addr[i][ADDR_W-1:2] == ld_addr[ADDR_W-1:2]) begin
                for (int b = 0; b < BE_W; b++) begin
                    if (ent_be[i][b]) begin
                        fwd_data[b*8 +: 8] = ent_data[i][b*8 +: 8];
                        fwd_be[b] = 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* sbuf_order.sv */
// Store buffer with load forwarding, in-order forcing and data-sync drain.
// What this block does
// - Non-peripheral loads with no buffered bytes bypass buffered stores while forcing bit clear
// - Every load compares against buffered store addresses
// - Matching load takes data from store buffer only when all its bytes are buffered
// - Forcing bit set: loads flush earlier stores first
// - Data sync flushes store buffer before later stores
// - Retried peripheral write holds later bus transactions
// - Data sync waits for pending peripheral writes
// - Data sync completes only when buffer empty
`timescale 1ns/1ns
`default_nettype none
module sbuf_order #(
    parameter int DEPTH = sbuf_pkg::SB_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_order_forcing_bit,
    input wire logic st_valid,
    input wire logic [sbuf_pkg::ADDR_W-1:0] st_addr,
    input wire logic [sbuf_pkg::DATA_W-1:0] st_data,
    input wire logic [sbuf_pkg::BE_W-1:0] st_be,
    input wire logic st_periph,
    output logic st_ready,
    input wire logic ld_valid,
    input wire logic [sbuf_pkg::ADDR_W-1:0] ld_addr,
    input wire logic ld_periph,
    output logic ld_ready,
    output logic ld_done,
    output logic [sbuf_pkg::DATA_W-1:0] ld_data,
    input wire logic data_sync_instruction,
    output logic sync_ready,
    output logic sync_done,
    output logic mem_req,
    output logic mem_we,
    output logic [sbuf_pkg::ADDR_W-1:0] mem_addr,
    output logic [sbuf_pkg::DATA_W-1:0] mem_wdata,
    output logic [sbuf_pkg::BE_W-1:0] mem_be,
    output logic mem_periph,
    input wire logic mem_ack,
    input wire logic mem_retry,
    input wire logic [sbuf_pkg::DATA_W-1:0] mem_rdata,
    output logic periph_busy
);
    import sbuf_pkg::*;

    typedef struct packed {
        mem_state_t st;
        logic [DEPTH-1:0] vld;
        logic [DEPTH-1:0][ADDR_W-1:0] addr;
        logic [DEPTH-1:0][DATA_W-1:0] data;
        logic [DEPTH-1:0][BE_W-1:0] be;
        logic [DEPTH-1:0] per;
        logic [CNT_W-1:0] cnt;
        logic io_r;
        logic sync_pend;
        logic ld_pend;
        logic [ADDR_W-1:0] ld_a;
        logic ld_per;
        logic ld_fin;
        logic [DATA_W-1:0] ld_d;
        logic st_rdy;
        logic ld_rdy;
        logic syn_rdy;
        logic syn_fin;
        logic req;
        logic we;
        logic [ADDR_W-1:0] maddr;
        logic [DATA_W-1:0] wd;
        logic [BE_W-1:0] mbe;
        logic mper;
        logic pbusy;
    } state_t;

    state_t cur_r, cur_nxt;
    logic [DATA_W-1:0] fwd_data;
    logic [BE_W-1:0] fwd_be;

    // Forwarding lookup for a load waiting in the capture slot.
    sbuf_match #(.DEPTH(DEPTH)) u_match (
        .ld_addr(cur_r.ld_a),
        .ent_vld(cur_r.vld),
        .ent_addr(cur_r.addr),
        .ent_data(cur_r.data),
        .ent_be(cur_r.be),
        .fwd_data(fwd_data),
        .fwd_be(fwd_be)
    );

    // True when all bytes of the load word are held in the buffer.
    function automatic logic full_hit(input logic [BE_W-1:0] be);
        full_hit = &be;
    endfunction

    // Next-state logic: accept requests, forward, drain and issue bus cycles.
    always_comb begin
        logic load_can_finish;
        load_can_finish = 1'b0;
        cur_nxt = cur_r;
        cur_nxt.io_r = in_order_forcing_bit;
        cur_nxt.ld_fin = 1'b0;
        cur_nxt.syn_fin = 1'b0;
        // Accept a store into the lowest free slot, at index cnt.
        if (st_valid && cur_r.st_rdy) begin
            cur_nxt.vld[cur_r.cnt[IDX_W-1:0]] = 1'b1;
            cur_nxt.addr[cur_r.cnt[IDX_W-1:0]] = st_addr;
            cur_nxt.data[cur_r.cnt[IDX_W-1:0]] = st_data;
            cur_nxt.be[cur_r.cnt[IDX_W-1:0]] = st_be;
            cur_nxt.per[cur_r.cnt[IDX_W-1:0]] = st_periph;
            cur_nxt.cnt = cur_r.cnt + CNT_W'(1);
        end
        if (ld_valid && cur_r.ld_rdy) begin
            cur_nxt.ld_pend = 1'b1;
            cur_nxt.ld_a = ld_addr;
            cur_nxt.ld_per = ld_periph;
        end
        if (data_sync_instruction && cur_r.syn_rdy) begin
            cur_nxt.sync_pend = 1'b1;
        end
        case (cur_r.st)
            ST_IDLE: begin
                if (cur_r.ld_pend && !cur_r.io_r && !cur_r.ld_per
                        && full_hit(fwd_be)) begin
                    cur_nxt.ld_d = fwd_data;
                    cur_nxt.ld_pend = 1'b0;
                    cur_nxt.ld_fin = 1'b1;
                end else if (cur_r.ld_pend && !cur_r.io_r && !cur_r.ld_per
                        && fwd_be == '0) begin
                    // Non-dependent load goes ahead of buffered stores.
                    cur_nxt.st = ST_LOAD;
                    cur_nxt.req = 1'b1;
                    cur_nxt.we = 1'b0;
                    cur_nxt.maddr = cur_r.ld_a;
                    cur_nxt.mper = 1'b0;
                end else if (cur_r.vld[0]) begin
                    // Drain the oldest store; loads that need it wait.
                    cur_nxt.st = ST_DRAIN;
                    cur_nxt.req = 1'b1;
                    cur_nxt.we = 1'b1;
                    cur_nxt.maddr = cur_r.addr[0];
                    cur_nxt.wd = cur_r.data[0];
                    cur_nxt.mbe = cur_r.be[0];
                    cur_nxt.mper = cur_r.per[0];
                    cur_nxt.pbusy = cur_r.per[0];
                end else if (cur_r.ld_pend) begin
                    // Buffer empty: in-order or peripheral load runs now.
                    load_can_finish = 1'b1;
                    cur_nxt.st = ST_LOAD;
                    cur_nxt.req = 1'b1;
                    cur_nxt.we = 1'b0;
                    cur_nxt.maddr = cur_r.ld_a;
                    cur_nxt.mper = cur_r.ld_per;
                end else if (cur_r.sync_pend && !cur_r.pbusy) begin
                    cur_nxt.sync_pend = 1'b0;
                    cur_nxt.syn_fin = 1'b1;
                end
            end
            ST_DRAIN: begin
                // A retried peripheral write keeps the bus owned.
                if (mem_ack && !mem_retry) begin
                    cur_nxt.req = 1'b0;
                    cur_nxt.pbusy = 1'b0;
                    cur_nxt.st = ST_IDLE;
                    for (int i = 0; i < DEPTH - 1; i++) begin
                        cur_nxt.vld[i] = cur_r.vld[i+1];
                        cur_nxt.addr[i] = cur_r.addr[i+1];
                        cur_nxt.data[i] = cur_r.data[i+1];
                        cur_nxt.be[i] = cur_r.be[i+1];
                        cur_nxt.per[i] = cur_r.per[i+1];
                    end
                    cur_nxt.vld[DEPTH-1] = 1'b0;
                    if (st_valid && cur_r.st_rdy) begin
                        cur_nxt.vld[cur_r.cnt[IDX_W-1:0] - IDX_W'(1)] = 1'b1;
                        cur_nxt.addr[cur_r.cnt[IDX_W-1:0] - IDX_W'(1)] = st_addr;
                        cur_nxt.data[cur_r.cnt[IDX_W-1:0] - IDX_W'(1)] = st_data;
                        cur_nxt.be[cur_r.cnt[IDX_W-1:0] - IDX_W'(1)] = st_be;
                        cur_nxt.per[cur_r.cnt[IDX_W-1:0] - IDX_W'(1)] = st_periph;
                        cur_nxt.cnt = cur_r.cnt;
                    end else begin
                        cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
                    end
                end
            end
            ST_LOAD: begin
                if (mem_ack && !mem_retry) begin
                    cur_nxt.req = 1'b0;
                    cur_nxt.ld_d = mem_rdata;
                    cur_nxt.ld_pend = 1'b0;
                    cur_nxt.ld_fin = 1'b1;
                    cur_nxt.st = ST_IDLE;
                end
            end
            default: begin
                cur_nxt.st = ST_IDLE;
                cur_nxt.req = 1'b0;
            end
        endcase
        // Ready flags look one cycle ahead; stores stop while a sync waits.
        cur_nxt.st_rdy = (cur_nxt.cnt < CNT_W'(DEPTH - 1)) && !cur_nxt.sync_pend;
        cur_nxt.ld_rdy = !cur_nxt.ld_pend && !cur_nxt.ld_fin && !load_can_finish;
        cur_nxt.syn_rdy = !cur_nxt.sync_pend && !cur_nxt.syn_fin;
        if (srst) begin
            cur_nxt = '0;
            cur_nxt.st = ST_IDLE;
            cur_nxt.io_r = IN_ORDER_RESET;
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        cur_r <= cur_nxt;
    end

    assign st_ready = cur_r.st_rdy;
    assign ld_ready = cur_r.ld_rdy;
    assign ld_done = cur_r.ld_fin;
    assign ld_data = cur_r.ld_d;
    assign sync_ready = cur_r.syn_rdy;
    assign sync_done = cur_r.syn_fin;
    assign mem_req = cur_r.req;
    assign mem_we = cur_r.we;
    assign mem_addr = cur_r.maddr;
    assign mem_wdata = cur_r.wd;
    assign mem_be = cur_r.mbe;
    assign mem_periph = cur_r.mper;
    assign periph_busy = cur_r.pbusy;
endmodule
`default_nettype wire

/* sbuf_order_properties.sv */
// Assertion checker for the store buffer ordering block.
`timescale 1ns/1ns
`default_nettype none
module sbuf_order_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic st_ready,
    input wire logic ld_valid,
    input wire logic ld_ready,
    input wire logic ld_done,
    input wire logic data_sync_instruction,
    input wire logic sync_ready,
    input wire logic sync_done,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [sbuf_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_periph,
    input wire logic mem_ack,
    input wire logic mem_retry,
    input wire logic periph_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Bus hold, retry blocking, sync completion and load answer timing.
    AST_REQ_HOLD: assert property (mem_req && !(mem_ack && !mem_retry) |=> mem_req && $stable(mem_addr))
        else $error("bus request dropped");
    AST_BUSY_SET: assert property (mem_req && mem_we && mem_periph && mem_ack && mem_retry |=> periph_busy)
        else $error("retried write not busy");
    AST_READ_WAIT: assert property (mem_req && !mem_we |-> !periph_busy)
        else $error("read passed retried write");
    AST_SYNC_EMPTY: assert property (sync_done |-> !periph_busy && !mem_req)
        else $error("sync done too early");
    AST_SYNC_MIN: assert property (data_sync_instruction && sync_ready |=> !sync_done)
        else $error("sync done in one cycle");
    AST_ST_BLOCK: assert property (data_sync_instruction && sync_ready |-> ##[1:2] !st_ready)
        else $error("store taken during sync");
    AST_LD_PULSE: assert property (ld_done |=> !ld_done)
        else $error("load done too long");
    AST_LD_ANSWER: assert property (ld_valid && ld_ready |=> !ld_done ##[1:60] ld_done)
        else $error("load not answered");
    COV_SYNC: cover property (sync_done);
    COV_RETRY: cover property (mem_retry);
    COV_LOAD: cover property (ld_done);
endmodule
bind sbuf_order sbuf_order_chk u_chk (.mclk, .srst, .st_ready, .ld_valid, .ld_ready, .ld_done,
    .data_sync_instruction, .sync_ready, .sync_done, .mem_req, .mem_we, .mem_addr, .mem_periph,
    .mem_ack, .mem_retry, .periph_busy);
`default_nettype wire

/* sbuf_pkg.sv */
// Shared constants and types for the store buffer ordering block.
package sbuf_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W = DATA_W / 8;
    localparam int SB_DEPTH = 4;
    localparam int IDX_W = $clog2(SB_DEPTH);
    localparam int CNT_W = $clog2(SB_DEPTH + 1);
    // Reset value of the in-order forcing bit: bypassing allowed.
    localparam logic IN_ORDER_RESET = 1'b0;
    // Memory controller states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DRAIN = 2'b01,
        ST_LOAD = 2'b10
    } mem_state_t;
endpackage

/* testbench.sv */
// Self-checking testbench for the store buffer ordering block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {logic [31:0] sa, sd, la, ex;} row_t;
    logic mclk = 0, srst = 1, in_order_forcing_bit = 0, st_valid = 0, st_periph = 0;
    logic ld_valid = 0, ld_periph = 0, data_sync_instruction = 0;
    logic [31:0] st_addr = 0, st_data = 0, ld_addr = 0, ld_data, mem_addr, mem_wdata, mem_rdata;
    logic [3:0] st_be = 0, mem_be;
    logic st_ready, ld_ready, ld_done, sync_ready, sync_done, mem_req, mem_we, mem_periph;
    logic mem_ack, mem_retry, periph_busy;
    int n_mismatch = 0, cmp_count = 0, cyc;
    // Status outputs gathered for the reset checks.
    logic [6:0] out_flags;
    assign out_flags = {st_ready, ld_ready, sync_ready, ld_done, sync_done, mem_req, periph_busy};
    row_t rows [4] = '{'{32'h0, 32'h1111_1111, 32'h0, 32'h1111_1111},
        '{32'h4, 32'h2222_2222, 32'h4, 32'h2222_2222},
        '{32'h8, 32'h3333_3333, 32'h30, 32'h5a5a_0030},
        '{32'hc, 32'h4444_4444, 32'h8, 32'h3333_3333}};
    always #5 mclk = ~mclk;
    sbuf_order DUT (.mclk, .srst, .in_order_forcing_bit, .st_valid, .st_addr, .st_data, .st_be,
        .st_periph, .st_ready, .ld_valid, .ld_addr, .ld_periph, .ld_ready, .ld_done, .ld_data,
        .data_sync_instruction, .sync_ready, .sync_done, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_be, .mem_periph, .mem_ack, .mem_retry, .mem_rdata, .periph_busy);
    bus_model partner (.mclk, .srst, .mem_req, .mem_we, .mem_periph, .mem_addr, .mem_wdata,
        .mem_be, .mem_ack, .mem_retry, .mem_rdata);
    // Comparison, bus tasks and the closing task.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic st(input logic [31:0] a, input logic [31:0] d, input logic [3:0] b, input logic p);
        @(negedge mclk);
        st_valid = 1;
        st_addr = a;
        st_data = d;
        st_be = b;
        st_periph = p;
        @(posedge mclk);
        while (!st_ready) @(posedge mclk);
        @(negedge mclk);
        st_valid = 0;
    endtask
    task automatic ld(input logic [31:0] a, input logic [31:0] exp, input logic p);
        @(negedge mclk);
        ld_valid = 1;
        ld_addr = a;
        ld_periph = p;
        @(posedge mclk);
        while (!ld_ready) @(posedge mclk);
        @(negedge mclk);
        ld_valid = 0;
        for (cyc = 0; !ld_done && cyc < 80; cyc++) @(negedge mclk);
        chk(32'(ld_done), 1);
        chk(ld_data, exp);
    endtask
    task automatic sy;
        @(negedge mclk);
        data_sync_instruction = 1;
        @(posedge mclk);
        while (!sync_ready) @(posedge mclk);
        @(negedge mclk);
        data_sync_instruction = 0;
        for (cyc = 1; !sync_done && cyc < 80; cyc++) @(negedge mclk);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence: reset, table of forwarding and bypass cases, then the awkward cases.
    initial begin
        repeat (6) @(negedge mclk);
        chk(32'(out_flags), 0);
        srst = 0;
        repeat (2) @(negedge mclk);
        // Store and load are offered together so that hits are still buffered.
        foreach (rows[i]) begin
            fork
                st(rows[i].sa, rows[i].sd, 4'hf, 1'b0);
                ld(rows[i].la, rows[i].ex, 1'b0);
            join
        end
        // A retried peripheral write keeps both stores buffered for the merge.
        st(32'h20, 32'h1234_5678, 4'hf, 1'b1);
        st(32'h10, 32'h1122_3344, 4'hf, 1'b0);
        fork
            st(32'h10, 32'haabb_ccdd, 4'h3, 1'b0);
            ld(32'h10, 32'h1122_ccdd, 1'b0);
        join
        chk(partner.m[4], 32'h5a5a_0010);
        // Forcing bit is used only for this short test stretch.
        in_order_forcing_bit = 1'b1;
        st(32'h14, 32'h5555_6666, 4'hf, 1'b0);
        ld(32'h14, 32'h5555_6666, 1'b0);
        chk(partner.m[5], 32'h5555_6666);
        ld(32'h38, 32'h5a5a_0038, 1'b0);
        in_order_forcing_bit = 1'b0;
        st(32'h3c, 32'h7777_8888, 4'hf, 1'b1);
        sy;
        chk(32'(sync_done), 1);
        chk(32'(cyc > 5), 1);
        chk(32'(periph_busy), 0);
        chk(partner.m[15], 32'h7777_8888);
        ld(32'h3c, 32'h7777_8888, 1'b0);
        // Semaphore release: update, read back, sync, then release write.
        st(32'h24, 32'h9999_aaaa, 4'hf, 1'b1);
        ld(32'h24, 32'h9999_aaaa, 1'b1);
        sy;
        chk(32'(sync_done), 1);
        st(32'h28, 32'h0000_0000, 4'hf, 1'b0);
        // Reset in mid-run must discard a buffered peripheral store.
        st(32'h2c, 32'hbbbb_cccc, 4'hf, 1'b1);
        srst = 1;
        repeat (2) @(negedge mclk);
        chk(32'(out_flags), 0);
        srst = 0;
        repeat (2) @(negedge mclk);
        chk(32'(out_flags), 32'h70);
        ld(32'h2c, 32'h5a5a_002c, 1'b0);
        report_and_stop;
    end
    // Watchdog against a hang.
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end
endmodule
`default_nettype wire
